// ==== core/plcg_cfg.svh ====
// Functional notes
// - Address pin low: reads answer at 4Dh, writes at 4Ch.
// - Address pin high: reads answer at 4Fh, writes at 4Eh.
// - Twelve registers: one write-only, eight read/write, three read-only.
// - Register 0 bit 0 resets 1; 0 gates detector by pin, 1 always on.
// - Register 0 bit 1 inverts detector enable input; resets 0.
// - Register 0 bits 2,3 pick reference/feedback trigger edge; 1 falling; reset 0.
// - Register 0 bit 4 picks feedback: 0 internal divider, 1 external input.
// - Register 0 bit 5 routes recovered (0) or conditioned (1) sync to aux pin.
// - Register 0 bits 6,7 enable loop-lock and delay-lock reporting; reset 1, 0.
// - Register 1: gain code bits 0-2, post-scaler bits 4-5 (div 2..16); reset 0.
// - 12-bit feedback divider from register 2 (low, FF) and 3 bits 0-3 (F).
// - Writing 5xh to register 8 resets loop, loads working registers 1-3.
// - Writing xAh to register 8 resets delay unit, loads working register 5.
// - Register 4 bits 0-5 hold phase-delay offset; reset 0.
// - Register 4 bit 7 selects filter: 0 external, 1 internal; reset 0.
// - Register 5 bits 0-1 delay resolution: 0=16, 1=32, 3=64, 2 reserved; reset 3.
// - Register 6 bits 0-4 enable the five clock and aux outputs; reset 0.
// - Register 6 bit 5 inverts the half-rate clock outputs; reset 0.
// - Register 6 bits 6-7 set single-ended clock scaler 1,2,4,8; reset 0.
// - Register 7: oscillator modulus bits 0-6 (reset 0), bit 7 reference select (reset 1).
// - Registers 10h, 11h read fixed version and revision codes.
// - Register 12h: bit 0 delay lock, bit 1 loop lock, bits 2-7 zero.
// - Status pin: low, single lock, or sync xor edge / divided oscillator when both.
`ifndef PLCG_CFG_SVH
`define PLCG_CFG_SVH
`define PLCG_DEV_ADDR_LOW   7'h26
`define PLCG_DEV_ADDR_HIGH  7'h27
`define PLCG_OFS_INPUT      8'h00
`define PLCG_OFS_LOOP       8'h01
`define PLCG_OFS_FBDIV_LO   8'h02
`define PLCG_OFS_FBDIV_HI   8'h03
`define PLCG_OFS_PHASE      8'h04
`define PLCG_OFS_RES        8'h05
`define PLCG_OFS_OUTEN      8'h06
`define PLCG_OFS_REFDIV     8'h07
`define PLCG_OFS_CMD        8'h08
`define PLCG_OFS_VER        8'h10
`define PLCG_OFS_REV        8'h11
`define PLCG_OFS_STATUS     8'h12
`define PLCG_RST_INPUT      8'h41
`define PLCG_RST_LOOP       8'h00
`define PLCG_RST_FBDIV_LO   8'hff
`define PLCG_RST_FBDIV_HI   8'h0f
`define PLCG_RST_PHASE      8'h00
`define PLCG_RST_RES        2'h3
`define PLCG_RST_OUTEN      8'h00
`define PLCG_RST_REFDIV     8'h80
`define PLCG_MASK_LOOP      8'h37
`define PLCG_MASK_FBDIV_HI  8'h0f
`define PLCG_MASK_PHASE     8'hbf
`define PLCG_CMD_LOOP       4'h5
`define PLCG_CMD_DELAY      4'ha
`define PLCG_BITS_PER_BYTE  4'h8
`define PLCG_BIT_GATE       0
`define PLCG_BIT_GATE_INV   1
`define PLCG_BIT_REF_EDGE   2
`define PLCG_BIT_FB_EDGE    3
`define PLCG_BIT_FB_SRC     4
`define PLCG_BIT_AUX_SEL    5
`define PLCG_FLD_REPORT     7:6
`define PLCG_BIT_REF_SEL    7
`endif

// ==== core/plcg_pkg.sv ====
package plcg_pkg;
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_WDATA,
        ST_WACK,
        ST_RDATA,
        ST_RACK
    } plcg_state_type;
endpackage : plcg_pkg

// ==== core/plcg_regs.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "plcg_cfg.svh"
module plcg_regs
    import plcg_pkg::*;
#(
    parameter logic [7:0] CHIP_VERSION = 8'h3c,  // Arbitrary value
    parameter logic [7:0] CHIP_REVISION = 8'h02, // Arbitrary value
    parameter logic [5:0] METAL_REVISION = 6'h00 // Arbitrary value
) (
    input  wire logic       ref_clk,
    input  wire logic       nrst,
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe,
    input  wire logic       bus_address_select_pin,
    input  wire logic       ext_detector_enable,
    input  wire logic       recovered_sync,
    input  wire logic       conditioned_sync,
    input  wire logic       divided_osc,
    input  wire logic       phase_delay_locked,
    input  wire logic       loop_locked,
    output logic            detector_enable,
    output logic            reference_edge_select,
    output logic            feedback_edge_select,
    output logic            feedback_source_select,
    output logic            aux_output_pin,
    output logic            status_pin,
    output logic [2:0]      detector_gain_code,
    output logic [1:0]      post_scaler_code,
    output logic [11:0]     feedback_divider,
    output logic [5:0]      phase_delay_offset,
    output logic            loop_filter_select,
    output logic [1:0]      phase_delay_resolution,
    output logic            diff_pixel_clock_enable,
    output logic            single_clock_enable,
    output logic            diff_half_clock_enable,
    output logic            single_half_clock_enable,
    output logic            aux_output_enable,
    output logic            half_clock_invert,
    output logic [1:0]      single_clock_scaler,
    output logic [6:0]      osc_divider_modulus,
    output logic            reference_select,
    output logic            loop_reset_pulse,
    output logic            delay_reset_pulse
);

    plcg_state_type state_r;
    logic [3:0]     bit_cnt_r;
    logic [7:0]     shift_r;
    logic [7:0]     tx_r;
    logic [7:0]     ptr_r;
    logic           ptr_phase_r;
    logic           master_ack_r;
    logic           scl_q;
    logic           sda_q;
    logic [7:0]     input_r;
    logic [7:0]     loop_buf_r;
    logic [7:0]     fblo_buf_r;
    logic [7:0]     fbhi_buf_r;
    logic [7:0]     phase_r;
    logic [1:0]     res_buf_r;
    logic [7:0]     outen_r;
    logic [7:0]     refdiv_r;
    logic [7:0]     loop_work_r;
    logic [7:0]     fblo_work_r;
    logic [7:0]     fbhi_work_r;
    logic [1:0]     res_work_r;
    logic           wr_en;
    logic [7:0]     wr_data;
    logic           scl_rise;
    logic           scl_fall;
    logic           bus_start;
    logic           bus_stop;
    logic           byte_done;
    logic           cmd_loop;
    logic           cmd_delay;

    // Seven-bit address this device answers to; bit 0 of the byte is direction
    function automatic logic addr_match(input logic [7:0] b, input logic sel);
        addr_match = (b[7:1] == (sel ? `PLCG_DEV_ADDR_HIGH : `PLCG_DEV_ADDR_LOW));
    endfunction : addr_match

    function automatic logic [7:0] reg_read(input logic [7:0] a);
        case (a)
            `PLCG_OFS_INPUT:    reg_read = input_r;
            `PLCG_OFS_LOOP:     reg_read = loop_buf_r;
            `PLCG_OFS_FBDIV_LO: reg_read = fblo_buf_r;
            `PLCG_OFS_FBDIV_HI: reg_read = fbhi_buf_r;
            `PLCG_OFS_PHASE:    reg_read = phase_r;
            `PLCG_OFS_RES:      reg_read = {METAL_REVISION, res_buf_r};
            `PLCG_OFS_OUTEN:    reg_read = outen_r;
            `PLCG_OFS_REFDIV:   reg_read = refdiv_r;
            `PLCG_OFS_VER:      reg_read = CHIP_VERSION;
            `PLCG_OFS_REV:      reg_read = CHIP_REVISION;
            `PLCG_OFS_STATUS:   reg_read = {6'h00, loop_locked, phase_delay_locked};
            default:            reg_read = 8'h00;  // Command register and holes read zero
        endcase
    endfunction : reg_read

    // Pins are synchronous; one stage of history is enough for edge detection
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl_in;
            sda_q <= sda_in;
        end
    end

    assign scl_rise  = scl_in & ~scl_q;
    assign scl_fall  = ~scl_in & scl_q;
    assign bus_start = scl_in & scl_q & sda_q & ~sda_in;
    assign bus_stop  = scl_in & scl_q & ~sda_q & sda_in;
    assign byte_done = scl_fall && (bit_cnt_r == `PLCG_BITS_PER_BYTE);
    assign wr_en     = (state_r == ST_WDATA) && byte_done && !ptr_phase_r;
    assign wr_data   = shift_r;

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            state_r      <= ST_IDLE;
            bit_cnt_r    <= 4'h0;
            shift_r      <= 8'h00;
            tx_r         <= 8'h00;
            ptr_r        <= 8'h00;
            ptr_phase_r  <= 1'b0;
            master_ack_r <= 1'b0;
        end else if (bus_stop) begin
            state_r <= ST_IDLE;
        end else if (bus_start) begin
            state_r   <= ST_ADDR;
            bit_cnt_r <= 4'h0;
        end else begin
            if (scl_rise && (state_r == ST_ADDR || state_r == ST_WDATA)) begin
                shift_r   <= {shift_r[6:0], sda_in};
                bit_cnt_r <= bit_cnt_r + 4'h1;
            end
            if (scl_rise && state_r == ST_RDATA) begin
                bit_cnt_r <= bit_cnt_r + 4'h1;
            end
            if (scl_rise && state_r == ST_RACK) begin
                master_ack_r <= ~sda_in;
            end
            case (state_r)
                ST_ADDR: begin
                    if (byte_done) begin
                        state_r <= addr_match(shift_r, bus_address_select_pin) ? ST_ADDR_ACK : ST_IDLE;
                    end
                end
                ST_ADDR_ACK: begin
                    if (scl_fall) begin
                        bit_cnt_r <= 4'h0;
                        if (shift_r[0]) begin
                            tx_r    <= reg_read(ptr_r);
                            ptr_r   <= ptr_r + 8'h01;
                            state_r <= ST_RDATA;
                        end else begin
                            ptr_phase_r <= 1'b1;
                            state_r     <= ST_WDATA;
                        end
                    end
                end
                ST_WDATA: begin
                    if (byte_done) begin
                        state_r <= ST_WACK;
                        if (ptr_phase_r) begin
                            ptr_r       <= shift_r;
                            ptr_phase_r <= 1'b0;
                        end else begin
                            ptr_r <= ptr_r + 8'h01;
                        end
                    end
                end
                ST_WACK: begin
                    if (scl_fall) begin
                        bit_cnt_r <= 4'h0;
                        state_r   <= ST_WDATA;
                    end
                end
                ST_RDATA: begin
                    if (byte_done) begin
                        state_r <= ST_RACK;
                    end else if (scl_fall) begin
                        tx_r <= {tx_r[6:0], 1'b0};
                    end
                end
                ST_RACK: begin
                    if (scl_fall) begin
                        bit_cnt_r <= 4'h0;
                        if (master_ack_r) begin
                            tx_r    <= reg_read(ptr_r);
                            ptr_r   <= ptr_r + 8'h01;
                            state_r <= ST_RDATA;
                        end else begin
                            state_r <= ST_IDLE;
                        end
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // Open-drain: only ever pull low
    assign sda_out = 1'b0;
    assign sda_oe  = (state_r == ST_ADDR_ACK) || (state_r == ST_WACK) || (state_r == ST_RDATA && !tx_r[7]);

    // Buffered side of the register file
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            input_r    <= `PLCG_RST_INPUT;
            loop_buf_r <= `PLCG_RST_LOOP;
            fblo_buf_r <= `PLCG_RST_FBDIV_LO;
            fbhi_buf_r <= `PLCG_RST_FBDIV_HI;
            phase_r    <= `PLCG_RST_PHASE;
            res_buf_r  <= `PLCG_RST_RES;
            outen_r    <= `PLCG_RST_OUTEN;
            refdiv_r   <= `PLCG_RST_REFDIV;
        end else if (wr_en) begin
            case (ptr_r)
                `PLCG_OFS_INPUT:    input_r    <= wr_data;
                `PLCG_OFS_LOOP:     loop_buf_r <= wr_data & `PLCG_MASK_LOOP;
                `PLCG_OFS_FBDIV_LO: fblo_buf_r <= wr_data;
                `PLCG_OFS_FBDIV_HI: fbhi_buf_r <= wr_data & `PLCG_MASK_FBDIV_HI;
                `PLCG_OFS_PHASE:    phase_r    <= wr_data & `PLCG_MASK_PHASE;
                `PLCG_OFS_RES:      res_buf_r  <= wr_data[1:0];
                `PLCG_OFS_OUTEN:    outen_r    <= wr_data;
                `PLCG_OFS_REFDIV:   refdiv_r   <= wr_data;
                default:            input_r    <= input_r; // Read-only and command offsets store nothing
            endcase
        end
    end

    assign cmd_loop  = wr_en && (ptr_r == `PLCG_OFS_CMD) && (wr_data[7:4] == `PLCG_CMD_LOOP);
    assign cmd_delay = wr_en && (ptr_r == `PLCG_OFS_CMD) && (wr_data[3:0] == `PLCG_CMD_DELAY);

    // Working copies change only on a matching command, so a half-written set never reaches the loop
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            loop_work_r      <= `PLCG_RST_LOOP;
            fblo_work_r      <= `PLCG_RST_FBDIV_LO;
            fbhi_work_r      <= `PLCG_RST_FBDIV_HI;
            loop_reset_pulse <= 1'b0;
        end else begin
            loop_reset_pulse <= cmd_loop;
            if (cmd_loop) begin
                loop_work_r <= loop_buf_r;
                fblo_work_r <= fblo_buf_r;
                fbhi_work_r <= fbhi_buf_r;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            res_work_r        <= `PLCG_RST_RES;
            delay_reset_pulse <= 1'b0;
        end else begin
            delay_reset_pulse <= cmd_delay;
            if (cmd_delay) begin
                res_work_r <= res_buf_r;
            end
        end
    end

    // Pin-facing logic, registered so the pins never glitch on decode
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            detector_enable <= 1'b0;
            aux_output_pin  <= 1'b0;
            status_pin      <= 1'b0;
        end else begin
            detector_enable <= input_r[`PLCG_BIT_GATE] | (ext_detector_enable ^ input_r[`PLCG_BIT_GATE_INV]);
            aux_output_pin  <= input_r[`PLCG_BIT_AUX_SEL] ? conditioned_sync : recovered_sync;
            case (input_r[`PLCG_FLD_REPORT])
                2'h0:    status_pin <= 1'b0;
                2'h1:    status_pin <= loop_locked;
                2'h2:    status_pin <= phase_delay_locked;
                default: status_pin <= refdiv_r[`PLCG_BIT_REF_SEL] ? divided_osc
                                        : (conditioned_sync ^ input_r[`PLCG_BIT_REF_EDGE]);
            endcase
        end
    end

    assign reference_edge_select    = input_r[`PLCG_BIT_REF_EDGE];
    assign feedback_edge_select     = input_r[`PLCG_BIT_FB_EDGE];
    assign feedback_source_select   = input_r[`PLCG_BIT_FB_SRC];
    assign detector_gain_code       = loop_work_r[2:0];
    assign post_scaler_code         = loop_work_r[5:4];
    assign feedback_divider         = {fbhi_work_r[3:0], fblo_work_r};
    assign phase_delay_offset       = phase_r[5:0];
    assign loop_filter_select       = phase_r[7];
    assign phase_delay_resolution   = res_work_r;
    assign diff_pixel_clock_enable  = outen_r[0];
    assign single_clock_enable      = outen_r[1];
    assign diff_half_clock_enable   = outen_r[2];
    assign single_half_clock_enable = outen_r[3];
    assign aux_output_enable        = outen_r[4];
    assign half_clock_invert        = outen_r[5];
    assign single_clock_scaler      = outen_r[7:6];
    assign osc_divider_modulus      = refdiv_r[6:0];
    assign reference_select         = refdiv_r[`PLCG_BIT_REF_SEL];

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    sequence s_cmd_write(logic [3:0] hi, logic [3:0] lo);
        wr_en && ptr_r == `PLCG_OFS_CMD && wr_data[7:4] == hi && wr_data[3:0] == lo;
    endsequence

    sequence s_bad_cmd;
        wr_en && ptr_r == `PLCG_OFS_CMD && wr_data[7:4] != `PLCG_CMD_LOOP && wr_data[3:0] != `PLCG_CMD_DELAY;
    endsequence

    chk_addr_low: assert property ((state_r == ST_ADDR) && byte_done && !bus_address_select_pin && !bus_stop
        && !bus_start && shift_r[7:1] == `PLCG_DEV_ADDR_LOW |=> state_r == ST_ADDR_ACK ##0 sda_oe)
        else $error("low address not acknowledged");
    chk_addr_high: assert property ((state_r == ST_ADDR) && byte_done && bus_address_select_pin && !bus_stop
        && !bus_start && shift_r[7:1] != `PLCG_DEV_ADDR_HIGH |=> state_r == ST_IDLE)
        else $error("foreign address acknowledged");
    chk_loop_load: assert property (s_cmd_write(`PLCG_CMD_LOOP, wr_data[3:0]) |=> loop_reset_pulse
        && feedback_divider == {$past(fbhi_buf_r[3:0]), $past(fblo_buf_r)} ##1 !loop_reset_pulse)
        else $error("loop command did not load working copies");
    chk_delay_load: assert property (s_cmd_write(wr_data[7:4], `PLCG_CMD_DELAY) |=> delay_reset_pulse
        && phase_delay_resolution == $past(res_buf_r))
        else $error("delay command did not load resolution");
    chk_bad_cmd: assert property (s_bad_cmd |=> !loop_reset_pulse && !delay_reset_pulse
        && $stable(feedback_divider) && $stable(phase_delay_resolution))
        else $error("unmatched command changed state");
    chk_status_off: assert property (input_r[7:6] == 2'h0 |=> !status_pin)
        else $error("status pin not low while disabled");
    chk_status_lock: assert property (input_r[7:6] == 2'h1 && $stable(input_r)
        |=> status_pin == $past(loop_locked))
        else $error("status pin not loop lock");
    chk_gate_mode: assert property (input_r[0] ##1 input_r[0] |-> detector_enable)
        else $error("detector gated while always enabled");
    chk_aux_route: assert property (input_r[5] |=> aux_output_pin == $past(conditioned_sync))
        else $error("aux pin not carrying conditioned sync");
    chk_ack_drive: assert property ((state_r == ST_WDATA) && byte_done && !bus_stop && !bus_start
        |=> sda_oe && !sda_out)
        else $error("write byte not acknowledged");

endmodule : plcg_regs
`default_nettype wire

// ==== sim/plcg_host.sv ====
`timescale 1ns/10ps
`default_nettype none
module plcg_host (
    input  wire logic ref_clk,
    input  wire logic dev_pull,
    output logic      scl,
    output logic      sda_line
);
    logic host_pull = 1'b0;
    initial scl = 1'b1;
    // Pull-up: released line floats high
    assign sda_line = ~(host_pull | dev_pull);
    // Four cycles a phase keeps every SCL phase above three samples
    task automatic gap();
        repeat (4) @(negedge ref_clk);
    endtask : gap
    task automatic start();
        host_pull = 1'b0;
        gap();
        scl = 1'b1;
        gap();
        host_pull = 1'b1;
        gap();
        scl = 1'b0;
    endtask : start
    task automatic stop();
        gap();
        host_pull = 1'b1;
        gap();
        scl = 1'b1;
        gap();
        host_pull = 1'b0;
        gap();
    endtask : stop
    // SDA moves only while SCL is low
    task automatic bit_io(input logic b, output logic r);
        gap();
        host_pull = ~b;
        gap();
        scl = 1'b1;
        gap();
        r = sda_line;
        scl = 1'b0;
    endtask : bit_io
    task automatic xfer(input logic [7:0] tx, input logic ak, output logic [7:0] rx, output logic ar);
        for (int i = 7; i >= 0; i--) begin
            bit_io(tx[i], rx[i]);
        end
        bit_io(ak, ar);
    endtask : xfer
endmodule : plcg_host
`default_nettype wire

// ==== sim/plcg_regs_tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin err_total++; \
    $display("Error %s expected %h seen %h", n, e, g); end end
module plcg_regs_tb_top;
    logic ref_clk = 0, nrst = 0, bus_address_select_pin = 0, ext_detector_enable = 0;
    logic recovered_sync = 0, conditioned_sync = 0, divided_osc = 0, phase_delay_locked = 0, loop_locked = 0;
    logic scl_in, sda_in, sda_out, sda_oe, detector_enable, reference_edge_select, feedback_edge_select;
    logic feedback_source_select, aux_output_pin, status_pin, loop_filter_select, diff_pixel_clock_enable;
    logic single_clock_enable, diff_half_clock_enable, single_half_clock_enable, aux_output_enable;
    logic half_clock_invert, reference_select, loop_reset_pulse, delay_reset_pulse;
    logic [2:0]  detector_gain_code;
    logic [1:0]  post_scaler_code, phase_delay_resolution, single_clock_scaler, k5;
    logic [11:0] feedback_divider;
    logic [5:0]  phase_delay_offset;
    logic [6:0]  osc_divider_modulus;
    logic [31:0] seed = 32'h8a1fb0dc, t;
    logic [7:0]  r0, r4, r6, r7, w1, w2, w3, w5, cmd, x, k1, k2, k3;
    logic [7:0]  rb [$];
    logic [7:0]  rst_tab [8] = '{8'h41, 8'h00, 8'hff, 8'h0f, 8'h00, 8'h03, 8'h00, 8'h80};
    logic [7:0]  cmds [4] = '{8'h33, 8'h5c, 8'h7a, 8'h5a};
    logic        a;
    int err_total = 0, tests_run = 0, n_loop = 0, n_delay = 0, e_loop = 0, e_delay = 0;

    always #10 ref_clk = ~ref_clk;
    // Counting catches pulses that last more than one cycle
    always @(negedge ref_clk) begin
        if (loop_reset_pulse === 1'b1) n_loop++;
        if (delay_reset_pulse === 1'b1) n_delay++;
    end

    plcg_host host (.ref_clk, .dev_pull(sda_oe), .scl(scl_in), .sda_line(sda_in));
    plcg_regs uut (.ref_clk, .nrst, .scl_in, .sda_in, .sda_out, .sda_oe, .bus_address_select_pin,
        .ext_detector_enable, .recovered_sync, .conditioned_sync, .divided_osc, .phase_delay_locked,
        .loop_locked, .detector_enable, .reference_edge_select, .feedback_edge_select, .feedback_source_select,
        .aux_output_pin, .status_pin, .detector_gain_code, .post_scaler_code, .feedback_divider,
        .phase_delay_offset, .loop_filter_select, .phase_delay_resolution, .diff_pixel_clock_enable,
        .single_clock_enable, .diff_half_clock_enable, .single_half_clock_enable, .aux_output_enable,
        .half_clock_invert, .single_clock_scaler, .osc_divider_modulus, .reference_select,
        .loop_reset_pulse, .delay_reset_pulse);

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    function automatic logic [7:0] dev_addr(input logic rd);
        return {6'h13, bus_address_select_pin, rd};
    endfunction : dev_addr
    function automatic logic exp_status(input logic [7:0] c, input logic s7);
        case (c[7:6])
            2'b00: return 1'b0;
            2'b01: return loop_locked;
            2'b10: return phase_delay_locked;
            default: return s7 ? divided_osc : (conditioned_sync ^ c[2]);
        endcase
    endfunction : exp_status
    task automatic no_ack();
        host.start();
        host.xfer(dev_addr(1'b0) ^ 8'h02, 1'b1, x, a);
        `CHK("foreign address ack", 1'b1, a)
        host.stop();
    endtask : no_ack
    task automatic wr(input logic [7:0] ptr, input logic [7:0] d [$]);
        host.start();
        host.xfer(dev_addr(1'b0), 1'b1, x, a);
        `CHK("write ack", 1'b0, a)
        host.xfer(ptr, 1'b1, x, a);
        foreach (d[i]) host.xfer(d[i], 1'b1, x, a);
        host.stop();
    endtask : wr
    task automatic rd(input logic [7:0] ptr, input int n);
        rb = {};
        host.start();
        host.xfer(dev_addr(1'b0), 1'b1, x, a);
        host.xfer(ptr, 1'b1, x, a);
        host.start();
        host.xfer(dev_addr(1'b1), 1'b1, x, a);
        `CHK("read ack", 1'b0, a)
        for (int i = 0; i < n; i++) begin
            host.xfer(8'hff, i == n - 1, x, a);
            rb.push_back(x);
        end
        host.stop();
    endtask : rd
    task automatic report_and_stop();
        $display("Checks %0d, mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : report_and_stop

    initial begin
        repeat (80000) @(posedge ref_clk);
        err_total++;
        $display("Error watchdog expired");
        report_and_stop();
    end

    initial begin
        {k1, k2, k3, k5} = {8'h00, 8'hff, 8'h0f, 2'h3};
        repeat (4) @(negedge ref_clk);
        nrst = 1'b1;
        rd(8'h00, 8);
        foreach (rst_tab[i]) `CHK("reset value", rst_tab[i], rb[i])
        `CHK("gate after reset", 1'b1, detector_enable)
        `CHK("sda drive level", 1'b0, sda_out)
        $display("test reset done");
        for (int it = 0; it < 8; it++) begin
            t = rnd();
            r0 = {it[1:0], t[5:0]};
            {r4, w5, r6, r7} = rnd();
            r7[7] = it[2];
            w5[1:0] = w5[1] ? 2'h3 : w5[1:0];
            {w1, w2, w3, x} = rnd();
            cmd = cmds[it[1:0]];
            bus_address_select_pin = it[0];
            no_ack();
            // Burst runs on into the command byte
            wr(8'h00, '{r0, w1, w2, w3, r4, w5, r6, r7, cmd});
            if (cmd[7:4] == 4'h5) begin
                {k1, k2, k3} = {w1, w2, w3};
                e_loop++;
            end
            if (cmd[3:0] == 4'ha) begin
                k5 = w5[1:0];
                e_delay++;
            end
            t = rnd();
            {ext_detector_enable, recovered_sync, conditioned_sync,
                divided_osc, phase_delay_locked, loop_locked} = t[5:0];
            repeat (2) @(negedge ref_clk);
            `CHK("gate", r0[0] | (ext_detector_enable ^ r0[1]), detector_enable)
            `CHK("edges", r0[4:2], {feedback_source_select, feedback_edge_select, reference_edge_select})
            `CHK("aux", r0[5] ? conditioned_sync : recovered_sync, aux_output_pin)
            `CHK("status pin", exp_status(r0, r7[7]), status_pin)
            `CHK("phase", {r4[7], r4[5:0]}, {loop_filter_select, phase_delay_offset})
            `CHK("enables", r6, {single_clock_scaler, half_clock_invert, aux_output_enable, single_half_clock_enable,
                diff_half_clock_enable, single_clock_enable, diff_pixel_clock_enable})
            `CHK("refdiv", r7, {reference_select, osc_divider_modulus})
            `CHK("loop work", {k1[2:0], k1[5:4]}, {detector_gain_code, post_scaler_code})
            `CHK("divider work", {k3[3:0], k2}, feedback_divider)
            `CHK("resolution work", k5, phase_delay_resolution)
            `CHK("loop pulses", e_loop, n_loop)
            `CHK("delay pulses", e_delay, n_delay)
            rd(8'h00, 8);
            `CHK("rb0", r0, rb[0])
            `CHK("rb1", w1 & 8'h37, rb[1])
            `CHK("rb2", w2, rb[2])
            `CHK("rb3", w3 & 8'h0f, rb[3])
            `CHK("rb4", r4 & 8'hbf, rb[4])
            `CHK("rb5", {6'h00, w5[1:0]}, rb[5])
            `CHK("rb6", r6, rb[6])
            `CHK("rb7", r7, rb[7])
            $display("test random %0d done", it);
        end
        wr(8'h10, '{8'h55, 8'haa});
        rd(8'h08, 11);
        `CHK("command reads", 8'h00, rb[0])
        `CHK("version", 8'h3c, rb[8])
        `CHK("revision", 8'h02, rb[9])
        `CHK("lock status", {6'h00, loop_locked, phase_delay_locked}, rb[10])
        $display("test read-only done");
        report_and_stop();
    end
endmodule : plcg_regs_tb_top
`default_nettype wire
